// file: hw/aux_ctrl_pkg.sv
package aux_ctrl_pkg;

    // ****************************************************
    // Register map
    // ****************************************************
    localparam logic [7:0] AUX_CTRL_ADDR  = 8'h8E;   // Special-function address
    localparam logic [7:0] AUX_CTRL_RESET = 8'h0C;   // 0X0X 1100b, X read as 0
    localparam logic [7:0] AUX_CTRL_WMASK = 8'hAF;   // Bits 6 and 4 not stored

    // Field positions
    localparam int BIT_SUPPRESS = 0;
    localparam int BIT_EXT_SEL  = 1;
    localparam int BIT_XRS_LO   = 2;
    localparam int BIT_XRS_HI   = 3;
    localparam int BIT_STRETCH  = 5;
    localparam int BIT_PU_DIS   = 7;

    // ****************************************************
    // Timing
    // ****************************************************
    localparam logic [4:0] STROBE_SHORT_CLKS = 5'h06;  // Normal read/write strobe
    localparam logic [4:0] STROBE_LONG_CLKS  = 5'h1E;  // Stretched strobe
    localparam logic [2:0] LATCH_DIV_X1      = 3'h6;   // Latch strobe every 6 clocks
    localparam logic [2:0] LATCH_DIV_X2      = 3'h3;   // Double-speed: every 3 clocks

    // Expanded RAM sizes in bytes, by size field
    localparam logic [10:0] XRAM_SIZE_0 = 11'h100;
    localparam logic [10:0] XRAM_SIZE_1 = 11'h200;
    localparam logic [10:0] XRAM_SIZE_2 = 11'h300;
    localparam logic [10:0] XRAM_SIZE_3 = 11'h400;

    typedef enum logic [1:0] {
        MODE_RESET,
        MODE_NORMAL,
        MODE_EMULATION
    } run_mode_e;

endpackage

// file: hw/aux_control.sv
// Functional notes
// [RULE1] The outside party requests emulation by holding the latch strobe low in reset with program strobe high.
// [RULE2] The latch strobe must stay low through reset release, and the device samples it then to enter emulation.
// [RULE3] In emulation the strobes and ports 1 to 3 are weakly pulled up, port 0 and the I2 port float, oscillator stays active.
// [RULE4] Emulation is left only by an ordinary reset taken without the entry condition.
// [RULE5] With the suppress bit set, the latch strobe pulses only for external data moves, code-table moves and external fetches.
// [RULE6] While suppressed, the latch strobe pin is weakly pulled high rather than driven.
// [RULE7] With the suppress bit clear, the latch strobe pulses every 6 clocks, or every 3 in double-speed mode.
// [RULE8] The pull-up disable bit enables weak port pull-ups when clear and disables them when set.
// [RULE9] The stretch bit selects a read/write strobe width of 6 clocks when clear and 30 when set.
// [RULE10] The size field selects 256, 512, 768 or 1024 bytes of expanded RAM.
// [RULE11] The external data select bit routes external data moves to internal RAM when clear, the bus when set.
// [RULE12] Reserved bits 6 and 4 are not stored and software must not write ones there.
// [RULE13] The register resets to 0X0X 1100b and is accessed only as a whole byte.
// [RULE14] The register answers at special-function address 8Eh.
// [RULE15] A register write takes effect from the cycle after the write; o_external_data_select and o_xram_size follow one cycle later.
//
// The strobed register port was decided locally.
`timescale 1ns/100ps

module aux_control (
    input  wire logic                     i_sys_clk,         // 10 MHz core clock
    input  wire logic                     i_resetn,          // Sync reset, active low
    input  wire logic [7:0]               i_addr,            // SFR address
    input  wire logic [7:0]               i_wdata,           // Write data
    input  wire logic                     i_wr,              // Write strobe
    input  wire logic                     i_rd,              // Read strobe
    output logic      [7:0]               o_rdata,           // Read data, cycle after strobe
    input  wire logic                     i_latch_strobe_pin,// Latch strobe pin level
    input  wire logic                     i_prog_strobe_pin, // Program strobe pin level
    input  wire logic                     i_double_speed,    // Double-speed mode select
    input  wire logic                     i_ext_access,      // Core: data/code move or ext fetch
    input  wire logic                     i_data_strobe_req, // Core: start read/write strobe
    output logic                          o_latch_strobe,    // Latch strobe output value
    output logic                          o_latch_strobe_oe, // Latch strobe driven
    output logic                          o_latch_strobe_pu, // Latch strobe weak pull-up
    output logic                          o_prog_strobe_pu,  // Program strobe weak pull-up
    output logic                          o_ports_pu,        // Ports 1..3 weak pull-up
    output logic                          o_port0_float,     // Port 0 floated
    output logic                          o_porti2_float,    // I2 port floated
    output logic                          o_osc_active,      // Oscillator pins active
    output logic                          o_emulation_isolation_mode, // Emulation active
    output logic                          o_data_strobe,     // Read/write strobe active
    output logic                          o_external_data_select,     // Moves to bus
    output logic      [10:0]              o_xram_size,       // Usable expanded RAM bytes
    output aux_ctrl_pkg::run_mode_e       o_run_mode         // Current mode
);
    import aux_ctrl_pkg::*;

    // ****************************************************
    // Pin synchronisers
    // ****************************************************
    logic [1:0] pin_async;      // Raw pin levels, bit 0 latch, bit 1 program
    logic [1:0] sync_meta_r;    // First stage, may go metastable
    logic [1:0] sync_pin_r;     // Second stage, safe to read
    logic       latch_pin_s;    // Latch strobe pin, synchronised
    logic       prog_pin_s;     // Program strobe pin, synchronised
    logic       rst_meta_r;
    logic       rst_seen_r;

    // Pins are driven by the emulator, not by this clock
    assign pin_async = {i_prog_strobe_pin, i_latch_strobe_pin};

    // Two-stage capture of each pin level
    generate
        for (genvar g = 0; g < 2; g++) begin : g_sync
            always_ff @(posedge i_sys_clk) begin
                sync_meta_r[g] <= pin_async[g];
                sync_pin_r[g]  <= sync_meta_r[g];
            end
        end
    endgenerate

    // Only the second stage feeds logic
    assign latch_pin_s = sync_pin_r[0];
    assign prog_pin_s  = sync_pin_r[1];

    // Remember reset was held, to catch its release;
    // delayed like the pins, so both views are equally old
    always_ff @(posedge i_sys_clk) begin
        rst_meta_r <= ~i_resetn;
        rst_seen_r <= rst_meta_r;
    end

    // ****************************************************
    // Size decode
    // ****************************************************
    // Size field to usable byte count
    function automatic logic [10:0] xram_size_of(input logic [1:0] sel);
        case (sel)
            2'h0:    xram_size_of = XRAM_SIZE_0;
            2'h1:    xram_size_of = XRAM_SIZE_1;
            2'h2:    xram_size_of = XRAM_SIZE_2;
            default: xram_size_of = XRAM_SIZE_3;
        endcase
    endfunction

    // ****************************************************
    // Register
    // ****************************************************
    logic [7:0] aux_ctrl_r;
    wire        reg_hit = (i_addr == AUX_CTRL_ADDR);  // [RULE14]

    // Whole-byte write, reserved bits dropped;
    // no bit access, so every write replaces all fields
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            aux_ctrl_r <= AUX_CTRL_RESET;                      // [RULE13]
        end else if (i_wr && reg_hit) begin
            aux_ctrl_r <= i_wdata & AUX_CTRL_WMASK;            // [RULE12] [RULE13] [RULE15]
        end
    end

    // Read data in the cycle after the strobe, zero otherwise;
    // reserved bits read as zero since they are never stored
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            o_rdata <= 8'h00;
        end else if (i_rd && reg_hit) begin
            o_rdata <= aux_ctrl_r;                             // [RULE12]
        end else begin
            o_rdata <= 8'h00;
        end
    end

    // ****************************************************
    // Register fields
    // ****************************************************
    logic       suppress;       // Latch strobe only on external access
    logic       stretch;        // Long read/write strobe
    logic       pu_dis;         // Port pull-ups off
    logic       ext_sel;        // External data moves go to the bus
    logic [1:0] size_sel;       // Expanded RAM size field

    // Named views of the stored byte
    assign suppress = aux_ctrl_r[BIT_SUPPRESS];             // [RULE5]
    assign stretch  = aux_ctrl_r[BIT_STRETCH];              // [RULE9]
    assign pu_dis   = aux_ctrl_r[BIT_PU_DIS];               // [RULE8]
    assign ext_sel  = aux_ctrl_r[BIT_EXT_SEL];              // [RULE11]
    assign size_sel = {aux_ctrl_r[BIT_XRS_HI], aux_ctrl_r[BIT_XRS_LO]};  // [RULE10]

    // ****************************************************
    // Mode tracking
    // ****************************************************
    run_mode_e mode_r;
    logic      entry_seen;      // Entry pattern present at reset release

    // Latch pin low and program pin high while reset was held
    assign entry_seen = rst_seen_r && !latch_pin_s && prog_pin_s;  // [RULE1] [RULE2]

    // Entry sampled at reset release, exit on plain reset;
    // a reset without the pattern always lands in normal mode
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            mode_r <= MODE_RESET;
        end else begin
            case (mode_r)
                MODE_RESET: begin
                    if (entry_seen) begin
                        mode_r <= MODE_EMULATION;              // [RULE1] [RULE2]
                    end else begin
                        mode_r <= MODE_NORMAL;                 // [RULE4]
                    end
                end
                MODE_NORMAL:    mode_r <= MODE_NORMAL;
                MODE_EMULATION: mode_r <= MODE_EMULATION;      // [RULE4]
                default:        mode_r <= MODE_NORMAL;
            endcase
        end
    end

    wire emul = (mode_r == MODE_EMULATION);
    wire run  = (mode_r == MODE_NORMAL);

    // ****************************************************
    // Latch strobe generator
    // ****************************************************
    logic [2:0] latch_cnt_r;
    logic [2:0] latch_cnt_nxt;
    logic [2:0] latch_div;
    logic       latch_tick;     // Start of a latch strobe period

    // Period length follows the speed mode; wrap at its end
    always_comb begin
        latch_div     = i_double_speed ? LATCH_DIV_X2 : LATCH_DIV_X1;   // [RULE7]
        latch_cnt_nxt = (latch_cnt_r >= latch_div - 3'h1) ? 3'h0 : latch_cnt_r + 3'h1;
        latch_tick    = (latch_cnt_r == 3'h0);
    end

    // Free-running period counter
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn || !run) begin
            latch_cnt_r <= 3'h0;
        end else begin
            latch_cnt_r <= latch_cnt_nxt;                      // [RULE7]
        end
    end

    // Pulse on period start; gated by suppress bit
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn || !run) begin
            o_latch_strobe    <= 1'b0;
            o_latch_strobe_oe <= 1'b0;
        end else if (!suppress) begin
            o_latch_strobe    <= latch_tick;                   // [RULE7]
            o_latch_strobe_oe <= 1'b1;
        end else if (i_ext_access) begin
            o_latch_strobe    <= latch_tick;                   // [RULE5]
            o_latch_strobe_oe <= 1'b1;
        end else begin
            o_latch_strobe    <= 1'b0;                         // [RULE5]
            o_latch_strobe_oe <= 1'b0;                         // [RULE6]
        end
    end

    // Weak pull-up on latch strobe when not driven;
    // also held in the cycle before the generator starts, so the pin never floats
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            o_latch_strobe_pu <= 1'b1;
        end else if (emul) begin
            o_latch_strobe_pu <= 1'b1;                         // [RULE3]
        end else begin
            o_latch_strobe_pu <= !run || (suppress && !i_ext_access);  // [RULE6]
        end
    end

    // ****************************************************
    // Data strobe timer
    // ****************************************************
    logic [4:0] strobe_cnt_r;
    logic       strobe_start;   // Request taken while idle

    // Requests while a strobe runs are dropped, not queued
    assign strobe_start = i_data_strobe_req && (strobe_cnt_r == 5'h00);

    // Load width from stretch bit, count down;
    // width fixed at the request, a later write does not cut it
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn || !run) begin
            strobe_cnt_r <= 5'h00;
        end else if (strobe_start) begin
            strobe_cnt_r <= stretch ? STROBE_LONG_CLKS : STROBE_SHORT_CLKS;  // [RULE9]
        end else if (strobe_cnt_r != 5'h00) begin
            strobe_cnt_r <= strobe_cnt_r - 5'h01;
        end
    end

    // Strobe high while counter loaded
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn || !run) begin
            o_data_strobe <= 1'b0;
        end else begin
            o_data_strobe <= strobe_start || (strobe_cnt_r > 5'h01);  // [RULE9]
        end
    end

    // ****************************************************
    // Pin state and configuration outputs
    // ****************************************************
    // Pin states forced by emulation mode
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            o_prog_strobe_pu           <= 1'b0;
            o_port0_float              <= 1'b0;
            o_porti2_float             <= 1'b0;
            o_osc_active               <= 1'b1;
            o_emulation_isolation_mode <= 1'b0;
        end else begin
            o_prog_strobe_pu           <= emul;                // [RULE3]
            o_port0_float              <= emul;                // [RULE3]
            o_porti2_float             <= emul;                // [RULE3]
            o_osc_active               <= 1'b1;                // [RULE3]
            o_emulation_isolation_mode <= emul;                // [RULE2]
        end
    end

    // Port pull-ups: always on in emulation, else from the register
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            o_ports_pu <= 1'b1;
        end else begin
            o_ports_pu <= emul || !pu_dis;                     // [RULE3] [RULE8]
        end
    end

    // Memory routing seen by the core, two cycles after a write
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            o_external_data_select <= 1'b0;
            o_xram_size            <= XRAM_SIZE_3;
        end else begin
            o_external_data_select <= ext_sel;                 // [RULE11] [RULE15]
            o_xram_size            <= xram_size_of(size_sel);  // [RULE10] [RULE15]
        end
    end

    // Mode as seen from outside
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            o_run_mode <= MODE_RESET;
        end else begin
            o_run_mode <= mode_r;
        end
    end

endmodule

// file: verification/aux_control_monitor.sv
`timescale 1ns/100ps
// ********************
// Port checker
// ********************
module aux_control_monitor (
    input wire logic               i_sys_clk,         // Clock
    input wire logic               i_resetn,          // Reset
    input wire logic [7:0]         i_addr,            // Address
    input wire logic [7:0]         i_wdata,           // Data
    input wire logic               i_wr,              // Write
    input wire logic               i_rd,              // Read
    input wire logic [7:0]         o_rdata,           // Read data
    input wire logic               i_double_speed,    // Fast
    input wire logic               i_data_strobe_req, // Request
    input wire logic               o_latch_strobe,    // Strobe
    input wire logic               o_latch_strobe_oe, // Driven
    input wire logic               o_latch_strobe_pu, // Pull-up
    input wire logic               o_ports_pu,        // Ports
    input wire logic               o_port0_float,     // Float
    input wire logic               o_emulation_isolation_mode, // Emulation
    input wire logic               o_data_strobe,     // Data strobe
    input wire logic               o_external_data_select, // Bus
    input wire logic [10:0]        o_xram_size,       // Size
    input wire aux_ctrl_pkg::run_mode_e o_run_mode    // Mode
);
    import aux_ctrl_pkg::*;
    logic [5:0] run_r; // High cycles of data strobe
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);
    // Quiet cycles up to the next latch pulse
    sequence gap6_s; (!o_latch_strobe)[*5] ##1 (o_latch_strobe || !o_latch_strobe_oe); endsequence
    sequence gap3_s; (!o_latch_strobe)[*2] ##1 (o_latch_strobe || !o_latch_strobe_oe); endsequence
    // Strobe length counter
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn || !o_data_strobe) begin
            run_r <= 6'h00;
        end else begin
            run_r <= run_r + 6'h01;
        end
    end
    reset_values_a: assert property (disable iff (1'b0)
        (!i_resetn) [*4] |-> o_run_mode == MODE_RESET && o_xram_size == XRAM_SIZE_3)
        else $error("reset outputs wrong");
    read_idle_a: assert property (!(i_rd && i_addr == AUX_CTRL_ADDR) |=>
        o_rdata == 8'h00) else $error("read data without read");
    reserved_zero_a: assert property ((o_rdata & 8'h50) == 8'h00)
        else $error("reserved bits set");
    write_effect_a: assert property (i_wr && i_addr == AUX_CTRL_ADDR |-> ##2
        o_external_data_select == $past(i_wdata[1], 2) &&
        o_xram_size[10:8] - 3'h1 == {1'b0, $past(i_wdata[3:2], 2)}) else $error("write late");
    emu_pins_a: assert property (o_emulation_isolation_mode |-> o_ports_pu &&
        o_port0_float && o_latch_strobe_pu && !o_latch_strobe_oe) else $error("emulation pins");
    emu_hold_a: assert property (o_emulation_isolation_mode |=>
        o_emulation_isolation_mode) else $error("emulation left");
    suppress_pin_a: assert property (o_run_mode == MODE_NORMAL &&
        $past(o_run_mode) == MODE_NORMAL && !o_latch_strobe_oe |->
        o_latch_strobe_pu && !o_latch_strobe) else $error("suppressed pin");
    latch_slow_a: assert property (o_latch_strobe && o_latch_strobe_oe &&
        !i_double_speed |=> gap6_s) else $error("latch period");
    latch_fast_a: assert property (o_latch_strobe && o_latch_strobe_oe &&
        i_double_speed |=> gap3_s) else $error("fast latch period");
    strobe_len_a: assert property ($fell(o_data_strobe) |->
        run_r == 6'h06 || run_r == 6'h1E) else $error("strobe width");
    strobe_start_a: assert property (i_data_strobe_req && !o_data_strobe &&
        o_run_mode == MODE_NORMAL |=> o_data_strobe) else $error("strobe start");
endmodule
bind aux_control aux_control_monitor u_mon (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_double_speed(i_double_speed), .i_data_strobe_req(i_data_strobe_req),
    .o_latch_strobe(o_latch_strobe), .o_latch_strobe_oe(o_latch_strobe_oe),
    .o_latch_strobe_pu(o_latch_strobe_pu), .o_ports_pu(o_ports_pu),
    .o_port0_float(o_port0_float), .o_emulation_isolation_mode(o_emulation_isolation_mode),
    .o_data_strobe(o_data_strobe), .o_external_data_select(o_external_data_select),
    .o_xram_size(o_xram_size), .o_run_mode(o_run_mode));

// file: verification/emulator_model.sv
`timescale 1ns/100ps
// ********************
// Emulator pin driver
// ********************
module emulator_model (
    input  wire logic i_enter,      // Request emulation
    output logic      o_pull_low,   // Latch strobe held low
    output logic      o_prog_level  // Program strobe level
);
    // Entry: latch low through reset release, program strobe high
    assign o_pull_low   = i_enter;
    assign o_prog_level = 1'b1;
endmodule

// file: verification/aux_control_test.sv
`timescale 1ns/100ps
// ********************
// Bench
// ********************
module aux_control_test;
    import aux_ctrl_pkg::*;
    logic        clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd_s = 1'b0, dbl = 1'b0, ext = 1'b0;
    logic        req = 1'b0, enter = 1'b0, pull_low, prog, pin, oe, pu, ppu, po, pf, pi, osc;
    logic        ls, emu, ds, sel;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata;
    logic [10:0] size;
    run_mode_e   mode;
    int          n_fail = 0, checks = 0;
    always #50 clk = ~clk;
    // Pin level from all drivers
    assign pin = oe ? ls : pull_low ? 1'b0 : pu ? 1'b1 : ~ls;
    aux_control dut (.i_sys_clk(clk), .i_resetn(rstn), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd_s), .o_rdata(rdata), .i_latch_strobe_pin(pin),
        .i_prog_strobe_pin(prog), .i_double_speed(dbl), .i_ext_access(ext),
        .i_data_strobe_req(req), .o_latch_strobe(ls), .o_latch_strobe_oe(oe),
        .o_latch_strobe_pu(pu), .o_prog_strobe_pu(ppu), .o_ports_pu(po),
        .o_port0_float(pf), .o_porti2_float(pi), .o_osc_active(osc),
        .o_emulation_isolation_mode(emu), .o_data_strobe(ds),
        .o_external_data_select(sel), .o_xram_size(size), .o_run_mode(mode));
    emulator_model partner (.i_enter(enter), .o_pull_low(pull_low), .o_prog_level(prog));
    task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        chk("read data", {3'h0, e}, {3'h0, rdata});
    endtask
    task automatic rst(input logic d, input logic em);
        @(posedge clk);
        rstn  <= 1'b0;
        dbl   <= d;
        enter <= em;
        repeat (8) @(posedge clk);
        chk("reset mode", MODE_RESET, mode);
        chk("reset pull-up", 11'h001, {10'h000, po});
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        enter <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk("run mode", em ? MODE_EMULATION : MODE_NORMAL, mode);
    endtask
    task automatic per(input logic [10:0] e);
        int n, k;
        n = 0;
        k = 0;
        while (ls !== 1'b1 && k < 20) begin
            @(posedge clk);
            #1;
            k++;
        end
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (ls !== 1'b1 && n < 20);
        chk("latch period", e, n[10:0]);
    endtask
    task automatic dlen(input logic [10:0] e);
        int n;
        n = 0;
        @(posedge clk);
        req <= 1'b1;
        for (int k = 0; k < 40; k++) begin
            @(posedge clk);
            req <= (k == 3); // Second request while busy is ignored
            #1;
            if (ds === 1'b1) n++;
        end
        chk("strobe width", e, n[10:0]);
    endtask
    task automatic end_of_test;
        if (n_fail == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Main sequence
    initial begin
        rst(1'b0, 1'b0);
        chk("size", XRAM_SIZE_3, size);
        rd_reg(AUX_CTRL_ADDR, AUX_CTRL_RESET);
        rd_reg(8'h8F, 8'h00);
        per(11'h006);
        dlen(11'h006);
        wr_reg(AUX_CTRL_ADDR, 8'hAF);
        chk("pull-up", 11'h000, {10'h000, po});
        chk("bus select", 11'h001, {10'h000, sel});
        rd_reg(AUX_CTRL_ADDR, 8'hAF);
        chk("latch drive", 11'h000, {10'h000, oe});
        chk("latch pull-up", 11'h001, {10'h000, pu});
        dlen(11'h01E);
        @(posedge clk);
        ext <= 1'b1;
        per(11'h006);
        @(posedge clk);
        ext <= 1'b0;
        for (int s = 0; s < 4; s++) begin
            wr_reg(AUX_CTRL_ADDR, {4'h0, s[1:0], 2'h0});
            chk("size", 11'h100 * (s + 1), size);
        end
        chk("bus select", 11'h000, {10'h000, sel});
        chk("pull-up", 11'h001, {10'h000, po});
        rst(1'b1, 1'b0);
        per(11'h003);
        rst(1'b0, 1'b1);
        chk("emulation pins", 11'h01F, {6'h00, emu, ppu, pf, pi, osc});
        rst(1'b0, 1'b0);
        chk("emulation", 11'h000, {10'h000, emu});
        end_of_test();
    end
    // Watchdog
    initial begin
        #1000000;
        n_fail++;
        end_of_test();
    end
endmodule
